// ===== hdl/cfs_sfr_state.sv
// Purpose: Architectural special register state of an 8-bit core
// Assumes: One clock, synchronous reset, direct register port from the core
// Notes: Read data answers one cycle after the read strobe
`include "cfs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module cfs_sfr_state (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire cfs_pkg::cfs_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_rvalid_o,
    input wire cfs_pkg::cfs_core_op_t core_op_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [7:0] ind_low_i,
    output var cfs_pkg::cfs_addr_out_t addr_o,
    output logic [15:0] program_counter_o,
    output logic [7:0] stack_pointer_o,
    output logic [7:0] accumulator_o,
    output logic [7:0] program_status_o,
    output logic [7:0] port_zero_latch_o,
    output logic [7:0] port_one_latch_o,
    output logic [7:0] port_two_latch_o,
    output logic [2:0] stretch_o,
    output logic [7:0] ext_irq_polarity_o,
    output logic baud_select_o
);
    import cfs_pkg::*;

    // ----------------------------------------
    // Register table
    // ----------------------------------------
    function automatic logic [7:0] cfs_addr_of(input int idx);
        case (idx)
            0: return `CFS_A_PORT_ZERO;
            1: return `CFS_A_DATA_POINTER_LO;
            2: return `CFS_A_DATA_POINTER_HI;
            3: return `CFS_A_ALT_DATA_POINTER_LO;
            4: return `CFS_A_ALT_DATA_POINTER_HI;
            5: return `CFS_A_WDOG_RELOAD;
            6: return `CFS_A_UART_SPEED;
            7: return `CFS_A_TIMER_FLAGS;
            8: return `CFS_A_TIMER_MODE;
            9: return `CFS_A_TMR0_LO;
            10: return `CFS_A_TMR1_LO;
            11: return `CFS_A_TMR0_HI;
            12: return `CFS_A_TMR1_HI;
            13: return `CFS_A_STRETCH;
            14: return `CFS_A_PORT_ONE;
            15: return `CFS_A_PTR_SELECT;
            16: return `CFS_A_SER0_CTRL;
            17: return `CFS_A_SER0_BUF;
            18: return `CFS_A_IRQ_EN_TWO;
            19: return `CFS_A_SER1_CTRL;
            20: return `CFS_A_SER1_BUF;
            21: return `CFS_A_SER1_RELOAD_LO;
            22: return `CFS_A_PORT_TWO;
            23: return `CFS_A_IRQ_EN_ZERO;
            24: return `CFS_A_IRQ_PRI_ZERO;
            25: return `CFS_A_SER0_RELOAD_LO;
            26: return `CFS_A_IRQ_EN_ONE;
            27: return `CFS_A_IRQ_PRI_ONE;
            28: return `CFS_A_SER0_RELOAD_HI;
            29: return `CFS_A_SER1_RELOAD_HI;
            30: return `CFS_A_MOVX_PAGE;
            31: return `CFS_A_IRQ_REQ;
            32: return `CFS_A_EXT_IRQ_POL;
            33: return `CFS_A_BAUD_CTRL;
            default: return `CFS_RST_ZERO;
        endcase
    endfunction

    // Hit flag in the top bit, table index below
    function automatic logic [6:0] cfs_find(input logic [7:0] a);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < `CFS_NUM_PLAIN; i++) begin
            if (cfs_addr_of(i) == a) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] cfs_rst_of(input int idx);
        case (cfs_addr_of(idx))
            `CFS_A_PORT_ZERO, `CFS_A_PORT_ONE: return `CFS_RST_PORT_HI;
            `CFS_A_STRETCH: return `CFS_RST_STRETCH;
            `CFS_A_SER0_RELOAD_LO: return `CFS_RST_SER0_RELOAD_LO;
            `CFS_A_SER0_RELOAD_HI, `CFS_A_SER1_RELOAD_HI: return `CFS_RST_RELOAD_HI;
            default: return `CFS_RST_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] cfs_mask_of(input int idx);
        if (cfs_addr_of(idx) == `CFS_A_BAUD_CTRL) begin
            return `CFS_BAUD_MASK;
        end
        return 8'hFF;
    endfunction

    localparam logic [5:0] I_P0 = 6'(cfs_find(`CFS_A_PORT_ZERO));
    localparam logic [5:0] I_P1 = 6'(cfs_find(`CFS_A_PORT_ONE));
    localparam logic [5:0] I_P2 = 6'(cfs_find(`CFS_A_PORT_TWO));
    localparam logic [5:0] I_DL = 6'(cfs_find(`CFS_A_DATA_POINTER_LO));
    localparam logic [5:0] I_DH = 6'(cfs_find(`CFS_A_DATA_POINTER_HI));
    localparam logic [5:0] I_AL = 6'(cfs_find(`CFS_A_ALT_DATA_POINTER_LO));
    localparam logic [5:0] I_AH = 6'(cfs_find(`CFS_A_ALT_DATA_POINTER_HI));
    localparam logic [5:0] I_STR = 6'(cfs_find(`CFS_A_STRETCH));
    localparam logic [5:0] I_SEL = 6'(cfs_find(`CFS_A_PTR_SELECT));
    localparam logic [5:0] I_PG = 6'(cfs_find(`CFS_A_MOVX_PAGE));
    localparam logic [5:0] I_POL = 6'(cfs_find(`CFS_A_EXT_IRQ_POL));
    localparam logic [5:0] I_BAUD = 6'(cfs_find(`CFS_A_BAUD_CTRL));

    // ----------------------------------------
    // Direct register port decode
    // ----------------------------------------
    logic [7:0] reg_q [0:`CFS_NUM_PLAIN-1];
    logic [7:0] stack_pointer;
    logic [7:0] accumulator;
    logic [7:0] multiply_scratch;
    logic [7:1] psw_q;
    logic [15:0] program_counter;
    logic [6:0] find_w;
    logic wr_sfr;
    logic [7:0] rd_val;
    logic [15:0] data_pointer;
    logic [15:0] product;
    logic mul_wrap;

    // Lower half belongs to RAM; indirect traffic never reaches this port
    assign wr_sfr = sfr_req_i.wr && sfr_req_i.addr[7];
    assign find_w = cfs_find(sfr_req_i.addr);

    // Unmapped addresses miss every table entry, so writes drop
    generate
        for (genvar g = 0; g < `CFS_NUM_PLAIN; g++) begin : g_plain
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    reg_q[g] <= cfs_rst_of(g);
                end else if (wr_sfr && find_w[6] && find_w[5:0] == 6'(g)) begin
                    reg_q[g] <= sfr_req_i.wdata & cfs_mask_of(g);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Stack pointer and program counter
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stack_pointer <= `CFS_RST_STACK;
        end else if (core_op_i.push) begin
            stack_pointer <= stack_pointer + 8'h01;
        end else if (core_op_i.pop) begin
            stack_pointer <= stack_pointer - 8'h01;
        end else if (wr_sfr && sfr_req_i.addr == `CFS_A_STACK) begin
            stack_pointer <= sfr_req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            program_counter <= `CFS_RST_PC;
        end else if (core_op_i.pc_load) begin
            program_counter <= core_op_i.pc_target;
        end else if (core_op_i.fetch) begin
            program_counter <= program_counter + 16'h0001;
        end
    end

    // ----------------------------------------
    // Accumulator, scratch byte and status
    // ----------------------------------------
    assign product = 16'(accumulator) * 16'(multiply_scratch);
    assign mul_wrap = product[15:8] != 8'h00;

    // Core results take priority over a same-cycle direct write
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            accumulator <= `CFS_RST_ZERO;
        end else if (core_op_i.mul) begin
            accumulator <= product[7:0];
        end else if (core_op_i.div) begin
            if (multiply_scratch != 8'h00) begin
                accumulator <= accumulator / multiply_scratch;
            end
        end else if (core_op_i.acc_we) begin
            accumulator <= core_op_i.acc_d;
        end else if (wr_sfr && sfr_req_i.addr == `CFS_A_ACCUM) begin
            accumulator <= sfr_req_i.wdata;
        end
    end

    // Divide by zero leaves both operands as they were
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            multiply_scratch <= `CFS_RST_ZERO;
        end else if (core_op_i.mul) begin
            multiply_scratch <= product[15:8];
        end else if (core_op_i.div) begin
            if (multiply_scratch != 8'h00) begin
                multiply_scratch <= accumulator % multiply_scratch;
            end
        end else if (wr_sfr && sfr_req_i.addr == `CFS_A_SCRATCH) begin
            multiply_scratch <= sfr_req_i.wdata;
        end
    end

    // Bit 0 is not stored; parity follows the accumulator directly
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            psw_q <= 7'h00;
        end else begin
            if (wr_sfr && sfr_req_i.addr == `CFS_A_STATUS) begin
                psw_q <= sfr_req_i.wdata[7:1];
            end
            if (core_op_i.mul || core_op_i.div) begin
                psw_q[`CFS_PSW_CARRY] <= 1'b0;
                psw_q[`CFS_PSW_WRAP] <= core_op_i.mul ? mul_wrap
                    : (multiply_scratch == 8'h00);
            end else if (core_op_i.flags_we) begin
                psw_q[`CFS_PSW_CARRY] <= core_op_i.carry_d;
                psw_q[`CFS_PSW_HALF] <= core_op_i.half_d;
                psw_q[`CFS_PSW_WRAP] <= core_op_i.wrap_d;
            end
        end
    end

    assign program_status_o = {psw_q, ^accumulator};

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rd_val = 8'h00;
        if (sfr_req_i.addr[7]) begin
            case (sfr_req_i.addr)
                `CFS_A_STACK: rd_val = stack_pointer;
                `CFS_A_STATUS: rd_val = program_status_o;
                `CFS_A_ACCUM: rd_val = accumulator;
                `CFS_A_SCRATCH: rd_val = multiply_scratch;
                default: rd_val = find_w[6] ? reg_q[find_w[5:0]] : 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_rvalid_o <= 1'b0;
        end else begin
            sfr_rvalid_o <= sfr_req_i.rd;
            if (sfr_req_i.rd) begin
                sfr_rdata_o <= rd_val;
            end
        end
    end

    // ----------------------------------------
    // Address generation and outputs
    // ----------------------------------------
    assign data_pointer = reg_q[I_SEL][0] ? {reg_q[I_AH], reg_q[I_AL]}
        : {reg_q[I_DH], reg_q[I_DL]};
    assign addr_o = '{bank_reg: {3'b000, psw_q[4], psw_q[3], reg_sel_i},
        code_tbl: data_pointer + {8'h00, accumulator},
        movx_ptr: data_pointer,
        movx_page: {reg_q[I_PG], ind_low_i}};

    assign program_counter_o = program_counter;
    assign stack_pointer_o = stack_pointer;
    assign accumulator_o = accumulator;
    assign port_zero_latch_o = reg_q[I_P0];
    assign port_one_latch_o = reg_q[I_P1];
    assign port_two_latch_o = reg_q[I_P2];
    assign stretch_o = reg_q[I_STR][2:0];
    assign ext_irq_polarity_o = reg_q[I_POL];
    assign baud_select_o = reg_q[I_BAUD][7];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking

    a_port_reset_vals:
    assert property (srst_i |=> port_zero_latch_o == 8'hFF && port_one_latch_o == 8'hFF
        && port_two_latch_o == 8'h00)
        else $error("port latches wrong after reset");

    a_stack_reset_seven:
    assert property (srst_i |=> stack_pointer_o == 8'h07)
        else $error("stack pointer not seven after reset");

    a_push_pre_inc:
    assert property (disable iff (srst_i)
        core_op_i.push |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
        else $error("push did not pre-increment stack pointer");

    a_bank_from_psw:
    assert property (disable iff (srst_i)
        wr_sfr && sfr_req_i.addr == 8'hD0
        |=> addr_o.bank_reg == {3'b000, $past(sfr_req_i.wdata[4:3]), reg_sel_i})
        else $error("bank select not taken from status write");

    a_bank_range:
    assert property (disable iff (srst_i) addr_o.bank_reg <= 8'h1F)
        else $error("working register address outside banks");

    a_parity_even:
    assert property (disable iff (srst_i) !(^{accumulator_o, program_status_o[0]}))
        else $error("parity bit not even");

    a_user_flag_kept:
    assert property (disable iff (srst_i)
        (core_op_i.flags_we || core_op_i.mul) && !(wr_sfr && sfr_req_i.addr == 8'hD0)
        |=> program_status_o[5] == $past(program_status_o[5])
            && program_status_o[1] == $past(program_status_o[1]))
        else $error("user flag changed by instruction");

    a_acc_load:
    assert property (disable iff (srst_i)
        core_op_i.acc_we && !core_op_i.mul && !core_op_i.div
        |=> accumulator_o == $past(core_op_i.acc_d))
        else $error("accumulator did not take result");

    a_mul_product:
    assert property (disable iff (srst_i)
        core_op_i.mul |=> {multiply_scratch, accumulator_o}
            == 16'($past(accumulator_o)) * 16'($past(multiply_scratch)))
        else $error("multiply result wrong");

    a_data_pointer_high_byte:
    assert property (disable iff (srst_i)
        wr_sfr && sfr_req_i.addr == 8'h83 && !data_pointer[15] && reg_q[I_SEL][0] == 1'b0
        |=> addr_o.movx_ptr[15:8] == $past(sfr_req_i.wdata))
        else $error("data pointer high byte not written");

    a_pc_from_zero:
    assert property (srst_i |=> program_counter_o == 16'h0000)
        else $error("program counter not zero after reset");

    a_fetch_step:
    assert property (disable iff (srst_i)
        core_op_i.fetch && !core_op_i.pc_load
        |=> program_counter_o == $past(program_counter_o) + 16'h0001)
        else $error("fetch did not advance program counter");

    a_psel_reset:
    assert property (srst_i |=> reg_q[I_SEL] == 8'h00)
        else $error("pointer select not zero after reset");

    a_page_high:
    assert property (disable iff (srst_i)
        wr_sfr && sfr_req_i.addr == 8'hBF |=> addr_o.movx_page[15:8] == $past(sfr_req_i.wdata))
        else $error("page register not on upper address");

    a_baud_low_zero:
    assert property (disable iff (srst_i) reg_q[I_BAUD][6:0] == 7'h00)
        else $error("unused baud control bits set");

    a_stretch_reset:
    assert property (srst_i |=> stretch_o == 3'b001)
        else $error("stretch not one after reset");

    a_direct_only:
    assert property (disable iff (srst_i)
        sfr_req_i.rd && !sfr_req_i.addr[7] |=> sfr_rvalid_o && sfr_rdata_o == 8'h00)
        else $error("low address answered by register port");

    a_carry_update:
    assert property (disable iff (srst_i)
        core_op_i.flags_we && !core_op_i.mul && !core_op_i.div
        |=> program_status_o[7] == $past(core_op_i.carry_d)
            && program_status_o[2] == $past(core_op_i.wrap_d))
        else $error("arithmetic flags not updated");

endmodule

`default_nettype wire

// ===== hdl/cfs_consts.svh
// Purpose: Addresses, bit positions and reset values of the core register state
// Assumes: Included by the core register state module only
// Notes: Addresses are direct special register addresses
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CFS_A_PORT_ZERO 8'h80
`define CFS_A_STACK 8'h81
`define CFS_A_DATA_POINTER_LO 8'h82
`define CFS_A_DATA_POINTER_HI 8'h83
`define CFS_A_ALT_DATA_POINTER_LO 8'h84
`define CFS_A_ALT_DATA_POINTER_HI 8'h85
`define CFS_A_WDOG_RELOAD 8'h86
`define CFS_A_UART_SPEED 8'h87
`define CFS_A_TIMER_FLAGS 8'h88
`define CFS_A_TIMER_MODE 8'h89
`define CFS_A_TMR0_LO 8'h8A
`define CFS_A_TMR1_LO 8'h8B
`define CFS_A_TMR0_HI 8'h8C
`define CFS_A_TMR1_HI 8'h8D
`define CFS_A_STRETCH 8'h8E
`define CFS_A_PORT_ONE 8'h90
`define CFS_A_PTR_SELECT 8'h92
`define CFS_A_SER0_CTRL 8'h98
`define CFS_A_SER0_BUF 8'h99
`define CFS_A_IRQ_EN_TWO 8'h9A
`define CFS_A_SER1_CTRL 8'h9B
`define CFS_A_SER1_BUF 8'h9C
`define CFS_A_SER1_RELOAD_LO 8'h9D
`define CFS_A_PORT_TWO 8'hA0
`define CFS_A_IRQ_EN_ZERO 8'hA8
`define CFS_A_IRQ_PRI_ZERO 8'hA9
`define CFS_A_SER0_RELOAD_LO 8'hAA
`define CFS_A_IRQ_EN_ONE 8'hB8
`define CFS_A_IRQ_PRI_ONE 8'hB9
`define CFS_A_SER0_RELOAD_HI 8'hBA
`define CFS_A_SER1_RELOAD_HI 8'hBB
`define CFS_A_MOVX_PAGE 8'hBF
`define CFS_A_IRQ_REQ 8'hC0
`define CFS_A_EXT_IRQ_POL 8'hC8
`define CFS_A_STATUS 8'hD0
`define CFS_A_BAUD_CTRL 8'hD8
`define CFS_A_ACCUM 8'hE0
`define CFS_A_SCRATCH 8'hF0
`define CFS_NUM_PLAIN 34

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define CFS_RST_ZERO 8'h00
`define CFS_RST_PORT_HI 8'hFF
`define CFS_RST_STACK 8'h07
`define CFS_RST_STRETCH 8'h01
`define CFS_RST_SER0_RELOAD_LO 8'hD9
`define CFS_RST_RELOAD_HI 8'h03
`define CFS_RST_PC 16'h0000
`define CFS_BAUD_MASK 8'h80
`define CFS_PSW_CARRY 7
`define CFS_PSW_HALF 6
`define CFS_PSW_WRAP 2

`endif

// ===== hdl/cfs_pkg.sv
// Purpose: Types shared by the core register state and its users
// Assumes: Nothing beyond the constants header
// Notes: Structs group request, core operation and address outputs
package cfs_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfs_sfr_req_t;

    typedef struct packed {
        logic fetch;
        logic pc_load;
        logic [15:0] pc_target;
        logic push;
        logic pop;
        logic acc_we;
        logic [7:0] acc_d;
        logic flags_we;
        logic carry_d;
        logic half_d;
        logic wrap_d;
        logic mul;
        logic div;
    } cfs_core_op_t;

    typedef struct packed {
        logic [7:0] bank_reg;
        logic [15:0] code_tbl;
        logic [15:0] movx_ptr;
        logic [15:0] movx_page;
    } cfs_addr_out_t;
endpackage

// ===== sim/test_cfs_sfr_state.sv
// Purpose: Self-checking bench for the core register state
// Assumes: Register port and core ops driven at the falling edge
// Notes: Unmapped reads expected as zero, the chosen read value
`timescale 1ns/1ns
`default_nettype none

module test_cfs_sfr_state;
    import cfs_pkg::*;

    logic clk_sys_i;
    logic srst_i;
    cfs_sfr_req_t req;
    cfs_core_op_t op;
    logic [2:0] reg_sel;
    logic [7:0] ind_low;
    logic [7:0] rdata, sp, acc, program_status, p0, p1, p2, pol;
    logic rvalid, baud;
    logic [2:0] stretch;
    logic [15:0] pc;
    cfs_addr_out_t addr;
    int mismatches = 0;
    int check_count = 0;

    cfs_sfr_state cfs_sfr_state_inst (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .sfr_req_i(req),
        .sfr_rdata_o(rdata),
        .sfr_rvalid_o(rvalid),
        .core_op_i(op),
        .reg_sel_i(reg_sel),
        .ind_low_i(ind_low),
        .addr_o(addr),
        .program_counter_o(pc),
        .stack_pointer_o(sp),
        .accumulator_o(acc),
        .program_status_o(program_status),
        .port_zero_latch_o(p0),
        .port_one_latch_o(p1),
        .port_two_latch_o(p2),
        .stretch_o(stretch),
        .ext_irq_polarity_o(pol),
        .baud_select_o(baud)
    );

    // ----------------------------------------
    // Clock, verdict and watchdog
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run is about 340 cycles; generous margin
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        mismatches++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_sys_i);
        req.wr = 1'b0;
    endtask

    // Read answer is fixed at one cycle, so no wait loop
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_sys_i);
        req.rd = 1'b0;
        chk8($sformatf("read valid %h", a), 8'h01, {7'h00, rvalid});
        chk8($sformatf("read data %h", a), exp, rdata);
    endtask

    task automatic run_op(input cfs_core_op_t o);
        @(negedge clk_sys_i);
        op = o;
        @(negedge clk_sys_i);
        op = '0;
    endtask

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            8'h80, 8'h90: return 8'hFF;
            8'h81: return 8'h07;
            8'h8E: return 8'h01;
            8'hAA: return 8'hD9;
            8'hBA, 8'hBB: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        cfs_core_op_t o;
        srst_i = 1'b1;
        req = '0;
        op = '0;
        reg_sel = 3'h0;
        ind_low = 8'h00;
        repeat (6) @(negedge clk_sys_i);
        srst_i = 1'b0;
        chk16("program counter", 16'h0000, pc);
        chk8("port zero", 8'hFF, p0);
        chk8("port one", 8'hFF, p1);
        chk8("port two", 8'h00, p2);
        chk8("stretch", 8'h01, {5'h00, stretch});
        for (int i = 8'h80; i <= 8'hFF; i++) begin
            rd_chk(8'(i), rst_val(8'(i)));
        end
        o = '0;
        o.push = 1'b1;
        run_op(o);
        chk8("stack push", 8'h08, sp);
        o = '0;
        o.pop = 1'b1;
        run_op(o);
        chk8("stack pop", 8'h07, sp);
        sfr_wr(8'h81, 8'h30);
        o = '0;
        o.push = 1'b1;
        run_op(o);
        chk8("stack written push", 8'h31, sp);
        o = '0;
        o.fetch = 1'b1;
        run_op(o);
        run_op(o);
        chk16("pc fetch", 16'h0002, pc);
        o.pc_load = 1'b1;
        o.pc_target = 16'h1234;
        run_op(o);
        chk16("pc jump", 16'h1234, pc);
        sfr_wr(8'hE0, 8'h55);
        chk8("parity even", 8'h00, {7'h00, program_status[0]});
        sfr_wr(8'hE0, 8'h57);
        chk8("parity odd", 8'h01, {7'h00, program_status[0]});
        o = '0;
        o.acc_we = 1'b1;
        o.acc_d = 8'h0F;
        run_op(o);
        chk8("accumulator", 8'h0F, acc);
        for (int n = 0; n < 4; n++) begin
            sfr_wr(8'hD0, 8'(n * 8));
            reg_sel = 3'(n + 4);
            #1;
            chk8("bank reg", 8'(n * 9 + 4), addr.bank_reg);
        end
        // Bit 0 written high must be dropped: parity of 0F is even
        sfr_wr(8'hD0, 8'h23);
        chk8("user flags", 8'h22, program_status);
        o = '0;
        o.flags_we = 1'b1;
        o.carry_d = 1'b1;
        o.half_d = 1'b1;
        o.wrap_d = 1'b1;
        run_op(o);
        rd_chk(8'hD0, 8'hE6);
        sfr_wr(8'h82, 8'h34);
        sfr_wr(8'h83, 8'h12);
        chk16("pointer move", 16'h1234, addr.movx_ptr);
        chk16("pointer table", 16'h1243, addr.code_tbl);
        sfr_wr(8'h84, 8'hCD);
        sfr_wr(8'h85, 8'hAB);
        sfr_wr(8'h92, 8'h01);
        chk16("alt pointer", 16'hABCD, addr.movx_ptr);
        sfr_wr(8'hBF, 8'h5A);
        ind_low = 8'h3C;
        #1;
        chk16("paged move", 16'h5A3C, addr.movx_page);
        sfr_wr(8'hD8, 8'hFF);
        rd_chk(8'hD8, 8'h80);
        chk8("baud select", 8'h01, {7'h00, baud});
        sfr_wr(8'hC8, 8'hA5);
        chk8("irq polarity", 8'hA5, pol);
        sfr_wr(8'hE0, 8'h10);
        sfr_wr(8'hF0, 8'h20);
        o = '0;
        o.mul = 1'b1;
        run_op(o);
        chk8("product low", 8'h00, acc);
        rd_chk(8'hF0, 8'h02);
        sfr_wr(8'hE0, 8'h17);
        sfr_wr(8'hF0, 8'h05);
        o = '0;
        o.div = 1'b1;
        run_op(o);
        chk8("quotient", 8'h04, acc);
        rd_chk(8'hF0, 8'h03);
        // Divide by zero keeps the operands and flags overflow
        sfr_wr(8'hF0, 8'h00);
        run_op(o);
        chk8("divide by zero", 8'h04, acc);
        chk8("divide by zero flags", 8'h01, {6'h00, program_status[7], program_status[2]});
        sfr_wr(8'h91, 8'hAA);
        rd_chk(8'h91, 8'h00);
        // 0x60 aliases the accumulator if bit 7 is not decoded
        sfr_wr(8'h60, 8'h99);
        chk8("low write", 8'h04, acc);
        rd_chk(8'h60, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
